// ---- mbr_hexrx.sv ----
// Purpose: Turns the character stream into frame start, byte and frame end events.
// Assumes: Characters come from logic on the same clock.
// Notes: A colon restarts a frame at any point, so a broken frame cannot lock it up.
`timescale 1ns/1ps
module mbr_hexrx (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Character stream
  input mbr_pkg::mbr_char_t rx,
  // Decoded events
  output mbr_pkg::mbr_rxev_t ev
);
  mbr_pkg::mbr_hx_t st_q, st_d;
  logic [3:0] hi_q, hi_d;
  mbr_pkg::mbr_rxev_t ev_d;
  logic [4:0] hv;

  always_comb begin
    hv = mbr_pkg::hex_val(rx.ch);
    st_d = st_q;
    hi_d = hi_q;
    ev_d = '0;
    if (rx.valid) begin
      if (rx.ch == mbr_pkg::CH_COLON) begin
        ev_d.start = 1'b1;
        st_d = mbr_pkg::H_HI;
      end else begin
        case (st_q)
          mbr_pkg::H_IDLE: st_d = mbr_pkg::H_IDLE;
          mbr_pkg::H_HI: begin
            if (hv[4]) begin
              hi_d = hv[3:0];
              st_d = mbr_pkg::H_LO;
            end else if (rx.ch == mbr_pkg::CH_CR) begin
              st_d = mbr_pkg::H_LF;
            end else begin
              ev_d.err = 1'b1;
              st_d = mbr_pkg::H_IDLE;
            end
          end
          mbr_pkg::H_LO: begin
            // Two hex characters make one byte, high nibble first
            ev_d.valid = hv[4];
            ev_d.err = !hv[4];
            ev_d.data = {hi_q, hv[3:0]};
            st_d = hv[4] ? mbr_pkg::H_HI : mbr_pkg::H_IDLE;
          end
          mbr_pkg::H_LF: begin
            ev_d.done = (rx.ch == mbr_pkg::CH_LF);
            ev_d.err = (rx.ch != mbr_pkg::CH_LF);
            st_d = mbr_pkg::H_IDLE;
          end
          default: st_d = mbr_pkg::H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= mbr_pkg::H_IDLE;
      hi_q <= 4'h0;
      ev <= '0;
    end else begin
      st_q <= st_d;
      hi_q <= hi_d;
      ev <= ev_d;
    end
  end
endmodule

// ---- mbr_host_model.sv ----
// Purpose: Behavioural serial master that sends hex-text requests and collects answers.
// Assumes: Drives at the falling edge; answer characters are taken at the rising edge.
// Notes: An idle data line shows the inverse of the last character, never a stale copy.
`timescale 1ns/1ps
module mbr_host_model (
  // Clock
  input wire logic clk,
  // Character link
  output mbr_pkg::mbr_char_t rx_out,
  output logic tx_ready,
  input mbr_pkg::mbr_char_t tx_in
);
  int stall_pct;

  initial begin
    rx_out = '0;
    tx_ready = 1'b0;
    stall_pct = 0;
  end

  function automatic logic [7:0] nib_chr(input logic [3:0] n, input logic low);
    logic [7:0] c;
    c = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    if (low && n >= 4'ha) c = c + 8'h20;
    return c;
  endfunction

  task automatic put_char(input logic [7:0] c);
    @(negedge clk);
    rx_out <= {1'b1, c};
  endtask

  // Check byte is appended here; lrc_flip lets a test corrupt it on purpose
  task automatic send_frame(input logic [7:0] b [32], input int n, input logic [7:0] lrc_flip);
    logic [7:0] sum;
    logic [7:0] v;
    logic low;
    sum = 8'h00;
    put_char(8'h3a);
    for (int i = 0; i <= n; i++) begin
      v = (i < n) ? b[i] : ((8'h00 - sum) ^ lrc_flip);
      sum = sum + v;
      low = ($urandom % 2) == 1;
      put_char(nib_chr(v[7:4], low));
      put_char(nib_chr(v[3:0], low));
    end
    put_char(8'h0d);
    put_char(8'h0a);
    @(negedge clk);
    rx_out <= {1'b0, ~rx_out.ch};
  endtask

  // Random stalls on the sink side; ends once the line feed is taken
  // Decides at the falling edge, where tx_in is settled; the rising edge then takes it
  task automatic get_answer(output logic [7:0] c [64], output int n, output logic ok);
    int t;
    logic r;
    n = 0;
    ok = 1'b0;
    t = 0;
    while (!ok && t < 2000) begin
      @(negedge clk);
      r = ($urandom % 100) >= stall_pct;
      tx_ready <= r;
      if (tx_in.valid === 1'b1 && r === 1'b1) begin
        if (n < 64) c[n] = tx_in.ch;
        n++;
        ok = (tx_in.ch === 8'h0a);
      end
      t++;
    end
    @(posedge clk);
    @(negedge clk);
    tx_ready <= 1'b0;
  endtask
endmodule

// ---- mbr_pkg.sv ----
// Purpose: Shared constants, types and helpers for the serial register-access slave.
// Assumes: One clock; characters arrive as one-cycle strobes from a UART on that clock.
// Notes: Register window is a small contiguous block of 16-bit words.
package mbr_pkg;
  // Framing and hex digit characters
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A_UP = 8'h41;
  localparam logic [7:0] CH_F_UP = 8'h46;
  localparam logic [7:0] CH_A_LO = 8'h61;
  localparam logic [7:0] CH_F_LO = 8'h66;
  localparam logic [3:0] NIB_TEN = 4'ha;
  // Function codes
  localparam logic [7:0] FC_RD = 8'h03;
  localparam logic [7:0] FC_WR1 = 8'h06;
  localparam logic [7:0] FC_WRN = 8'h10;
  localparam logic [7:0] FC_RW = 8'h17;
  // Register window
  localparam logic [15:0] REG_BASE = 16'h0040;
  localparam logic [15:0] REG_SPAN = 16'h0020;
  localparam int REG_NUM = 32;
  localparam logic [15:0] MAX_QTY = 16'h0008;
  localparam logic [15:0] ONE_QTY = 16'h0001;
  localparam logic [4:0] IX_TEMP_INT = 5'h00;
  localparam logic [4:0] IX_TEMP_EXT = 5'h01;
  localparam logic [4:0] IX_TEMP_AVG = 5'h02;
  localparam logic [4:0] IX_TARGET = 5'h11;
  localparam logic [4:0] IX_OFFSET = 5'h12;
  // Request byte positions
  localparam int BUF_N = 32;
  localparam logic [4:0] OF_SLAVE = 5'h00;
  localparam logic [4:0] OF_FC = 5'h01;
  localparam logic [4:0] OF_A_HI = 5'h02;
  localparam logic [4:0] OF_A_LO = 5'h03;
  localparam logic [4:0] OF_Q_HI = 5'h04;
  localparam logic [4:0] OF_Q_LO = 5'h05;
  localparam logic [4:0] OF_S_DAT = 5'h04;
  localparam logic [4:0] OF_W_BC = 5'h06;
  localparam logic [4:0] OF_W_DAT = 5'h07;
  localparam logic [4:0] OF_RW_WA = 5'h06;
  localparam logic [4:0] OF_RW_WQ = 5'h08;
  localparam logic [4:0] OF_RW_BC = 5'h0a;
  localparam logic [4:0] OF_RW_DAT = 5'h0b;
  // Request frame lengths in bytes, LRC included; answer lengths and positions leave the LRC out
  localparam logic [5:0] LEN_FIX = 6'h07;
  localparam logic [5:0] LEN_W_HDR = 6'h08;
  localparam logic [5:0] LEN_RW_HDR = 6'h0c;
  localparam logic [5:0] RSP_RD_HDR = 6'h03;
  localparam logic [5:0] RSP_ECHO = 6'h06;
  localparam logic [5:0] RSP_HI_POS = 6'h02;

  typedef struct packed {
    logic valid;
    logic [7:0] ch;
  } mbr_char_t;

  typedef struct packed {
    logic start;
    logic valid;
    logic done;
    logic err;
    logic [7:0] data;
  } mbr_rxev_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_WR = 2'b10, ST_TX = 2'b11} mbr_st_t;
  typedef enum logic [2:0] {
    P_COLON = 3'b000, P_HI = 3'b001, P_LO = 3'b010, P_CR = 3'b011, P_LF = 3'b100
  } mbr_ph_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_HI = 2'b01, H_LO = 2'b10, H_LF = 2'b11} mbr_hx_t;

  // Returns {valid, nibble}
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [7:0] t;
    t = 8'h00;
    hex_val = 5'h00;
    if (c >= CH_0 && c <= CH_9) begin
      t = c - CH_0;
      hex_val = {1'b1, t[3:0]};
    end else if (c >= CH_A_UP && c <= CH_F_UP) begin
      t = c - CH_A_UP;
      hex_val = {1'b1, t[3:0] + NIB_TEN};
    end else if (c >= CH_A_LO && c <= CH_F_LO) begin
      t = c - CH_A_LO;
      hex_val = {1'b1, t[3:0] + NIB_TEN};
    end
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < NIB_TEN) ? CH_0 + {4'h0, n} : CH_A_UP + {4'h0, n - NIB_TEN};
  endfunction
endpackage

// ---- mbr_slave.sv ----
// Purpose: Serial slave that reads and writes 16-bit registers on hex-text requests.
// Assumes: Host is the master; one request at a time, half duplex.
// Notes: Bad frames are dropped silently; no negative answer is built.
`timescale 1ns/1ps
module mbr_slave #(
  parameter logic [7:0] SLAVE_ADDR = 8'h01
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Character link
  input mbr_pkg::mbr_char_t rx_in,
  input wire logic tx_ready,
  output mbr_pkg::mbr_char_t tx_out,
  // Sensor values
  input wire logic [15:0] temp_int,
  input wire logic [15:0] temp_ext,
  input wire logic [15:0] temp_avg,
  // Settings
  output logic [15:0] target_temp,
  output logic [15:0] offset_temp
);
  mbr_pkg::mbr_rxev_t ev;
  mbr_pkg::mbr_st_t st_q, st_d;
  mbr_pkg::mbr_ph_t ph_q, ph_d;
  mbr_pkg::mbr_char_t tx_q, tx_d;
  logic rcv_q, rcv_d;
  logic [5:0] cnt_q, cnt_d, ti_q, ti_d, tn_q, tn_d;
  logic [7:0] sum_q, sum_d, tsum_q, tsum_d, fc_q, fc_d, cur;
  logic [7:0] buf_q [mbr_pkg::BUF_N];
  logic [7:0] buf_d [mbr_pkg::BUF_N];
  logic [15:0] regs_q [mbr_pkg::REG_NUM];
  logic [15:0] regs_d [mbr_pkg::REG_NUM];
  logic [4:0] ra_q, ra_d, rq_q, rq_d, wa_q, wa_d, wq_q, wq_d, dof_q, dof_d, wi_q, wi_d;
  logic [4:0] widx, didx;
  logic [15:0] wdata, a1, q1, a2, q2;
  logic ok, is_wr, is_rd, load;
  logic [5:0] roff;
  logic [15:0] rword;

  mbr_hexrx u_hexrx (
    .clk(clk),
    .rstn(rstn),
    .rx(rx_in),
    .ev(ev)
  );

  function automatic logic rng_ok(input logic [15:0] a, input logic [15:0] q);
    rng_ok = (q != 16'h0000) && (q <= mbr_pkg::MAX_QTY) && (a >= mbr_pkg::REG_BASE) &&
             (({1'b0, a} + {1'b0, q}) <= ({1'b0, mbr_pkg::REG_BASE} + {1'b0, mbr_pkg::REG_SPAN}));
  endfunction

  function automatic logic [15:0] rd_word(input logic [4:0] k);
    case (k)
      mbr_pkg::IX_TEMP_INT: rd_word = temp_int;
      mbr_pkg::IX_TEMP_EXT: rd_word = temp_ext;
      mbr_pkg::IX_TEMP_AVG: rd_word = temp_avg;
      default: rd_word = regs_q[k];
    endcase
  endfunction

  // Request checks; address and quantity fields are high byte first
  always_comb begin
    a1 = {buf_q[mbr_pkg::OF_A_HI], buf_q[mbr_pkg::OF_A_LO]};
    q1 = {buf_q[mbr_pkg::OF_Q_HI], buf_q[mbr_pkg::OF_Q_LO]};
    a2 = {buf_q[mbr_pkg::OF_RW_WA], buf_q[mbr_pkg::OF_RW_WA + 5'h01]};
    q2 = {buf_q[mbr_pkg::OF_RW_WQ], buf_q[mbr_pkg::OF_RW_WQ + 5'h01]};
    case (buf_q[mbr_pkg::OF_FC])
      mbr_pkg::FC_RD: ok = (cnt_q == mbr_pkg::LEN_FIX) && rng_ok(a1, q1);
      mbr_pkg::FC_WR1: ok = (cnt_q == mbr_pkg::LEN_FIX) && rng_ok(a1, mbr_pkg::ONE_QTY);
      mbr_pkg::FC_WRN: ok = rng_ok(a1, q1) &&
          (buf_q[mbr_pkg::OF_W_BC] == {q1[6:0], 1'b0}) &&
          (cnt_q == mbr_pkg::LEN_W_HDR + {q1[4:0], 1'b0});
      mbr_pkg::FC_RW: ok = rng_ok(a1, q1) && rng_ok(a2, q2) &&
          (buf_q[mbr_pkg::OF_RW_BC] == {q2[6:0], 1'b0}) &&
          (cnt_q == mbr_pkg::LEN_RW_HDR + {q2[4:0], 1'b0});
      default: ok = 1'b0;
    endcase
    // Sum over every byte including the check byte must be zero
    ok = ok && (buf_q[mbr_pkg::OF_SLAVE] == SLAVE_ADDR) && (sum_q == 8'h00);
  end

  assign is_wr = (fc_q != mbr_pkg::FC_RD);
  assign is_rd = (fc_q == mbr_pkg::FC_RD) || (fc_q == mbr_pkg::FC_RW);
  assign widx = wa_q + wi_q;
  assign didx = dof_q + {wi_q[3:0], 1'b0};
  assign wdata = {buf_q[didx], buf_q[didx + 5'h01]};
  assign load = (st_q == mbr_pkg::ST_TX) && (!tx_q.valid || tx_ready);
  assign roff = ti_q - mbr_pkg::RSP_RD_HDR;

  // Next answer byte
  always_comb begin
    // Part-select of a function result is not portable, so the word is held first
    rword = rd_word(ra_q + roff[5:1]);
    if (ti_q == tn_q) begin
      cur = 8'h00 - tsum_q;
    end else if (!is_rd || ti_q < mbr_pkg::RSP_HI_POS) begin
      cur = buf_q[ti_q[4:0]];
    end else if (ti_q == mbr_pkg::RSP_HI_POS) begin
      cur = {2'b00, rq_q, 1'b0};
    end else begin
      cur = roff[0] ? rword[7:0] : rword[15:8];
    end
  end

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    rcv_d = rcv_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    buf_d = buf_q;
    fc_d = fc_q;
    ra_d = ra_q;
    rq_d = rq_q;
    wa_d = wa_q;
    wq_d = wq_q;
    dof_d = dof_q;
    wi_d = wi_q;
    ti_d = ti_q;
    tn_d = tn_q;
    tsum_d = tsum_q;
    tx_d = tx_q;
    if (tx_ready) begin
      tx_d.valid = 1'b0;
    end
    case (st_q)
      mbr_pkg::ST_IDLE: begin
        if (ev.start) begin
          rcv_d = 1'b1;
          cnt_d = 6'h00;
          sum_d = 8'h00;
        end else if (ev.err) begin
          rcv_d = 1'b0;
        end else if (ev.valid && rcv_q) begin
          // An over-long frame is dropped rather than wrapped
          if (cnt_q == mbr_pkg::BUF_N[5:0]) begin
            rcv_d = 1'b0;
          end else begin
            buf_d[cnt_q[4:0]] = ev.data;
            cnt_d = cnt_q + 6'h01;
            sum_d = sum_q + ev.data;
          end
        end else if (ev.done && rcv_q) begin
          rcv_d = 1'b0;
          st_d = mbr_pkg::ST_EXEC;
        end
      end
      mbr_pkg::ST_EXEC: begin
        fc_d = buf_q[mbr_pkg::OF_FC];
        ra_d = a1[4:0] - mbr_pkg::REG_BASE[4:0];
        rq_d = q1[4:0];
        wi_d = 5'h00;
        ti_d = 6'h00;
        tsum_d = 8'h00;
        ph_d = mbr_pkg::P_COLON;
        wa_d = a1[4:0] - mbr_pkg::REG_BASE[4:0];
        case (buf_q[mbr_pkg::OF_FC])
          mbr_pkg::FC_WR1: begin
            wq_d = mbr_pkg::ONE_QTY[4:0];
            dof_d = mbr_pkg::OF_S_DAT;
          end
          mbr_pkg::FC_WRN: begin
            wq_d = q1[4:0];
            dof_d = mbr_pkg::OF_W_DAT;
          end
          default: begin
            // Combined request writes its second range before reading the first
            wa_d = a2[4:0] - mbr_pkg::REG_BASE[4:0];
            wq_d = q2[4:0];
            dof_d = mbr_pkg::OF_RW_DAT;
          end
        endcase
        if (buf_q[mbr_pkg::OF_FC] == mbr_pkg::FC_RD || buf_q[mbr_pkg::OF_FC] == mbr_pkg::FC_RW) begin
          tn_d = mbr_pkg::RSP_RD_HDR + {q1[4:0], 1'b0};
        end else begin
          tn_d = mbr_pkg::RSP_ECHO;
        end
        if (!ok) begin
          st_d = mbr_pkg::ST_IDLE;
        end else if (buf_q[mbr_pkg::OF_FC] == mbr_pkg::FC_RD) begin
          st_d = mbr_pkg::ST_TX;
        end else begin
          st_d = mbr_pkg::ST_WR;
        end
      end
      mbr_pkg::ST_WR: begin
        wi_d = wi_q + 5'h01;
        if (wi_q == wq_q - 5'h01) begin
          st_d = mbr_pkg::ST_TX;
        end
      end
      mbr_pkg::ST_TX: begin
        if (load) begin
          tx_d.valid = 1'b1;
          case (ph_q)
            mbr_pkg::P_COLON: begin
              tx_d.ch = mbr_pkg::CH_COLON;
              ph_d = mbr_pkg::P_HI;
            end
            mbr_pkg::P_HI: begin
              tx_d.ch = mbr_pkg::hex_chr(cur[7:4]);
              ph_d = mbr_pkg::P_LO;
            end
            mbr_pkg::P_LO: begin
              tx_d.ch = mbr_pkg::hex_chr(cur[3:0]);
              tsum_d = tsum_q + cur;
              ti_d = ti_q + 6'h01;
              ph_d = (ti_q == tn_q) ? mbr_pkg::P_CR : mbr_pkg::P_HI;
            end
            mbr_pkg::P_CR: begin
              tx_d.ch = mbr_pkg::CH_CR;
              ph_d = mbr_pkg::P_LF;
            end
            default: begin
              tx_d.ch = mbr_pkg::CH_LF;
              ph_d = mbr_pkg::P_COLON;
              st_d = mbr_pkg::ST_IDLE;
            end
          endcase
        end
      end
      default: st_d = mbr_pkg::ST_IDLE;
    endcase
  end

  // Register storage; temperature words shadow the sensor inputs on read
  always_comb begin
    regs_d = regs_q;
    if (st_q == mbr_pkg::ST_WR && is_wr) begin
      regs_d[widx] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= mbr_pkg::ST_IDLE;
      ph_q <= mbr_pkg::P_COLON;
      tx_q <= '0;
      rcv_q <= 1'b0;
      cnt_q <= 6'h00;
      sum_q <= 8'h00;
      fc_q <= 8'h00;
      {ra_q, rq_q, wa_q, wq_q, dof_q, wi_q} <= '0;
      ti_q <= 6'h00;
      tn_q <= 6'h00;
      tsum_q <= 8'h00;
      for (int i = 0; i < mbr_pkg::BUF_N; i++) begin
        buf_q[i] <= 8'h00;
      end
      for (int i = 0; i < mbr_pkg::REG_NUM; i++) begin
        regs_q[i] <= 16'h0000;
      end
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      tx_q <= tx_d;
      rcv_q <= rcv_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      fc_q <= fc_d;
      {ra_q, rq_q, wa_q, wq_q, dof_q, wi_q} <= {ra_d, rq_d, wa_d, wq_d, dof_d, wi_d};
      ti_q <= ti_d;
      tn_q <= tn_d;
      tsum_q <= tsum_d;
      buf_q <= buf_d;
      regs_q <= regs_d;
    end
  end

  assign tx_out = tx_q;
  assign target_temp = regs_q[mbr_pkg::IX_TARGET];
  assign offset_temp = regs_q[mbr_pkg::IX_OFFSET];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_wr_store;
    (st_q == mbr_pkg::ST_WR) |=> (regs_q[$past(widx)] == $past(wdata));
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("write lost");
  property p_target;
    (st_q == mbr_pkg::ST_WR && widx == mbr_pkg::IX_TARGET) |=> (target_temp == $past(wdata));
  endproperty
  a_target: assert property (p_target) else $error("target not written");
  property p_colon;
    (load && ph_q == mbr_pkg::P_COLON) |=> (tx_q.valid && tx_q.ch == mbr_pkg::CH_COLON);
  endproperty
  a_colon: assert property (p_colon) else $error("frame lacks colon");
  property p_crlf;
    (tx_q.valid && tx_q.ch == mbr_pkg::CH_CR && tx_ready) |=>
      (tx_q.valid && tx_q.ch == mbr_pkg::CH_LF);
  endproperty
  a_crlf: assert property (p_crlf) else $error("CR not followed by LF");
  property p_lrc;
    (load && ph_q == mbr_pkg::P_CR) |-> (tsum_q == 8'h00);
  endproperty
  a_lrc: assert property (p_lrc) else $error("bad check byte");
  property p_count;
    (st_q == mbr_pkg::ST_TX && is_rd && ti_q == mbr_pkg::RSP_HI_POS) |-> (cur == {2'b00, rq_q, 1'b0});
  endproperty
  a_count: assert property (p_count) else $error("bad byte count");
  property p_temp;
    (load && is_rd && ph_q == mbr_pkg::P_HI && ti_q == mbr_pkg::RSP_RD_HDR && ra_q == 5'h00) |=>
      (tx_q.ch == mbr_pkg::hex_chr($past(temp_int[15:12])));
  endproperty
  a_temp: assert property (p_temp) else $error("temperature word wrong");
  property p_echo;
    (st_q == mbr_pkg::ST_TX && !is_rd && ti_q < tn_q) |-> (cur == buf_q[ti_q[4:0]] && tn_q == 6'h06);
  endproperty
  a_echo: assert property (p_echo) else $error("echo mismatch");
  property p_rw;
    (st_q == mbr_pkg::ST_EXEC && ok && buf_q[mbr_pkg::OF_FC] == mbr_pkg::FC_RW) |=>
      (st_q == mbr_pkg::ST_WR) ##[1:8] (st_q == mbr_pkg::ST_TX);
  endproperty
  a_rw: assert property (p_rw) else $error("combined request not done");

  c_rd: cover property (st_q == mbr_pkg::ST_EXEC && ok && buf_q[mbr_pkg::OF_FC] == mbr_pkg::FC_RD);
  c_wrn: cover property (st_q == mbr_pkg::ST_WR && fc_q == mbr_pkg::FC_WRN && wq_q == 5'h02);
  c_rw: cover property (load && ph_q == mbr_pkg::P_LF && fc_q == mbr_pkg::FC_RW);
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the serial register-access slave.
// Assumes: Slave address 01; fixed seed; inputs change at the falling edge.
// Notes: A shadow copy of the register window predicts every read answer; the temperature words come from the sensor inputs.
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rstn;
  mbr_pkg::mbr_char_t rx_in;
  mbr_pkg::mbr_char_t tx_out;
  logic tx_ready;
  logic [15:0] temp_int, temp_ext, temp_avg, target_temp, offset_temp;
  int num_errors;
  int checks_done;
  logic [15:0] shadow [32];
  logic [15:0] wv [8];
  logic [7:0] req [32];
  logic [7:0] exp_b [24];
  logic [7:0] got [64];
  int got_n;
  logic got_ok;
  logic quiet;

  mbr_slave #(.SLAVE_ADDR(8'h01)) dut_u (.clk(clk), .rstn(rstn), .rx_in(rx_in),
    .tx_ready(tx_ready), .tx_out(tx_out), .temp_int(temp_int), .temp_ext(temp_ext),
    .temp_avg(temp_avg), .target_temp(target_temp), .offset_temp(offset_temp));
  mbr_host_model host_u (.clk(clk), .rx_out(rx_in), .tx_ready(tx_ready), .tx_in(tx_out));

  always #20 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
    checks_done++;
    if (seen !== expv) begin
      num_errors++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  function automatic logic [15:0] exp_word(input logic [15:0] a);
    if (a == 16'h0040) return temp_int;
    if (a == 16'h0041) return temp_ext;
    if (a == 16'h0042) return temp_avg;
    return shadow[a[4:0]];
  endfunction

  task automatic put16(input int i, input logic [15:0] v);
    req[i] = v[15:8];
    req[i + 1] = v[7:0];
  endtask

  task automatic eput16(input int i, input logic [15:0] v);
    exp_b[i] = v[15:8];
    exp_b[i + 1] = v[7:0];
  endtask

  task automatic xfer(input int nq, input int ne, input string what);
    logic [7:0] sum;
    host_u.send_frame(req, nq, 8'h00);
    host_u.get_answer(got, got_n, got_ok);
    check(got_ok, 1'b1, {what, " no answer"});
    if (!got_ok) give_verdict();
    sum = 8'h00;
    for (int i = 0; i < ne; i++) sum = sum + exp_b[i];
    exp_b[ne] = 8'h00 - sum;
    check(got_n, 2 * ne + 5, {what, " length"});
    check(got[0], 8'h3a, {what, " start"});
    for (int i = 0; i <= ne; i++) begin
      check({got[2 * i + 1], got[2 * i + 2]}, {hexc(exp_b[i][7:4]), hexc(exp_b[i][3:0])}, what);
    end
    check({got[2 * ne + 3], got[2 * ne + 4]}, 16'h0d0a, {what, " end"});
    repeat (2) @(negedge clk);
  endtask

  task automatic set_words(input int pos, input logic [15:0] wa, input int wq);
    logic [15:0] t;
    req[pos - 1] = 8'(2 * wq);
    for (int i = 0; i < wq; i++) begin
      t = wa + 16'(i);
      put16(pos + 2 * i, wv[i]);
      shadow[t[4:0]] = wv[i];
    end
  endtask

  task automatic do_read(input logic [15:0] a, input int q);
    req[0] = 8'h01;
    req[1] = mbr_pkg::FC_RD;
    put16(2, a);
    put16(4, q[15:0]);
    exp_b[0] = 8'h01;
    exp_b[1] = mbr_pkg::FC_RD;
    exp_b[2] = 8'(2 * q);
    for (int i = 0; i < q; i++) eput16(3 + 2 * i, exp_word(a + 16'(i)));
    xfer(6, 3 + 2 * q, "read");
  endtask

  task automatic do_wr1(input logic [15:0] a, input logic [15:0] v);
    req[0] = 8'h01;
    req[1] = mbr_pkg::FC_WR1;
    put16(2, a);
    put16(4, v);
    shadow[a[4:0]] = v;
    for (int i = 0; i < 6; i++) exp_b[i] = req[i];
    xfer(6, 6, "single write");
  endtask

  task automatic do_wrn(input logic [15:0] a, input int q);
    req[0] = 8'h01;
    req[1] = mbr_pkg::FC_WRN;
    put16(2, a);
    put16(4, q[15:0]);
    set_words(7, a, q);
    for (int i = 0; i < 6; i++) exp_b[i] = req[i];
    xfer(7 + 2 * q, 6, "multi write");
  endtask

  task automatic do_rw(input logic [15:0] ra, input int rq, input logic [15:0] wa, input int wq);
    req[0] = 8'h01;
    req[1] = mbr_pkg::FC_RW;
    put16(2, ra);
    put16(4, rq[15:0]);
    put16(6, wa);
    put16(8, wq[15:0]);
    set_words(11, wa, wq);
    exp_b[0] = 8'h01;
    exp_b[1] = mbr_pkg::FC_RW;
    exp_b[2] = 8'(2 * rq);
    for (int i = 0; i < rq; i++) eput16(3 + 2 * i, exp_word(ra + 16'(i)));
    xfer(11 + 2 * wq, 3 + 2 * rq, "read write");
  endtask

  task automatic rand_words();
    for (int i = 0; i < 8; i++) wv[i] = 16'($urandom);
  endtask

  initial begin
    int q;
    clk = 1'b0;
    rstn = 1'b0;
    temp_int = 16'h09e1;
    temp_ext = 16'hfc22;
    temp_avg = 16'hfc22;
    num_errors = 0;
    checks_done = 0;
    for (int i = 0; i < 32; i++) shadow[i] = 16'h0000;
    void'($urandom(4283));
    repeat (4) @(negedge clk);
    check({tx_out.valid, target_temp, offset_temp}, 33'h0, "reset values");
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    $display("Test reset done");
    do_read(16'h0040, 3);
    wv[0] = 16'h0bb8;
    wv[1] = 16'h0032;
    do_wrn(16'h0051, 2);
    check({target_temp, offset_temp}, {16'h0bb8, 16'h0032}, "settings");
    rand_words();
    do_rw(16'h0040, 3, 16'h0051, 2);
    check({target_temp, offset_temp}, {wv[0], wv[1]}, "settings rw");
    do_rw(16'h0051, 2, 16'h0051, 2);
    $display("Test documented examples done");
    // Corrupt check byte, then a foreign slave address: both must be dropped
    for (int k = 0; k < 2; k++) begin
      req[0] = (k == 0) ? 8'h01 : 8'h02;
      req[1] = mbr_pkg::FC_RD;
      put16(2, 16'h0040);
      put16(4, 16'h0001);
      host_u.send_frame(req, 6, (k == 0) ? 8'h5a : 8'h00);
      quiet = 1'b1;
      repeat (60) begin
        @(negedge clk);
        if (tx_out.valid !== 1'b0) quiet = 1'b0;
      end
      check(quiet, 1'b1, "dropped frame answered");
      @(negedge clk);
    end
    $display("Test dropped frames done");
    rand_words();
    do_wrn(16'h0058, 8);
    do_read(16'h0058, 8);
    do_wr1(16'h005f, wv[3]);
    do_read(16'h005f, 1);
    $display("Test window edges done");
    for (int n = 0; n < 12; n++) begin
      host_u.stall_pct = $urandom % 50;
      temp_int = 16'($urandom);
      temp_ext = 16'($urandom);
      rand_words();
      q = 1 + $urandom % 8;
      case ($urandom % 4)
        0: do_wr1(16'h0043 + 16'($urandom % 29), wv[0]);
        1: do_wrn(16'h0043 + 16'($urandom % (30 - q)), q);
        2: do_rw(16'h0040 + 16'($urandom % (33 - q)), q, 16'h0043 + 16'($urandom % (30 - q)), q);
        default: do_read(16'h0040 + 16'($urandom % (33 - q)), q);
      endcase
    end
    $display("Test random traffic done");
    give_verdict();
  end
endmodule
